// >>> dv/rsi_assertions.sv
`timescale 1ns/1ps
module rsi_assertions (
    input wire logic        clock,                 // Core clock
    input wire logic        rst_n,                 // Power-on reset
    input wire logic        psel,                  // APB select
    input wire logic        penable,               // APB enable
    input wire logic        pwrite,                // APB write
    input wire logic [7:0]  paddr,                 // APB byte address
    input wire logic [31:0] prdata,                // APB read data
    input wire logic [2:0]  supply_below,          // Supply monitor
    input wire logic        external_reset_pin_n,  // Reset pin
    input wire logic        wakeup_event,          // Wakeup request
    input wire logic        watchdog_timeout,      // Watchdog expiry
    input wire logic        core_reset,            // Internal reset
    input wire logic [11:0] restart_address,       // Fetch address
    input wire logic [1:0]  brownout_level_select  // Threshold choice
);
    logic       sel_low;    // Supply below chosen level
    logic       any_src;
    logic [5:0] quiet_cnt;  // Edges without any source
    logic [2:0] hist;       // Reset level at last three edges
    logic       rd_rst;     // Read sampled deep inside reset
    logic [5:0] ridx;

    assign sel_low = (brownout_level_select == 2'b00) ? supply_below[0] :
                     (brownout_level_select == 2'b01) ? supply_below[1] : supply_below[2];
    assign any_src = sel_low | ~external_reset_pin_n | wakeup_event | watchdog_timeout;
    assign ridx    = paddr[7:2];
    assign rd_rst  = psel & penable & ~pwrite & (&hist);

    always_ff @(posedge clock) begin
        hist <= {hist[1:0], core_reset};
    end

    always_ff @(posedge clock) begin
        if (!rst_n || any_src)
            quiet_cnt <= 6'h00;
        else if (quiet_cnt != 6'h3f)
            quiet_cnt <= quiet_cnt + 6'h01;
    end

    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);

    chk_bor_enter: assert property (sel_low |=> core_reset)
        else $error("core not in reset during brown-out");
    chk_hold_early: assert property (quiet_cnt inside {[6'd1:6'd45]} |-> core_reset)
        else $error("reset released before hold time");
    chk_bor_release: assert property (quiet_cnt == 6'd60 |-> !core_reset)
        else $error("reset not released after sources cleared");
    chk_src_reset: assert property (!external_reset_pin_n || watchdog_timeout |=> core_reset)
        else $error("reset source did not reset core");
    chk_restart_addr: assert property (core_reset |=> restart_address == 12'hfff)
        else $error("restart address not top of memory");
    chk_option_init: assert property (rd_rst && ridx == 6'h06 |-> prdata[7:0] == 8'hff)
        else $error("option register not all ones");
    chk_mode_init: assert property (rd_rst && ridx == 6'h07 |-> prdata[7:0] == 8'h1f)
        else $error("mode register wrong in reset");
    chk_tmr_count: assert property (rd_rst && ridx == 6'h2c |-> prdata[7:0] == 8'h01)
        else $error("timer count low byte wrong in reset");
    chk_tmr_compare: assert property (rd_rst && ridx == 6'h27 |-> prdata[7:0] == 8'h00)
        else $error("timer compare byte not cleared");
    chk_tmr_control: assert property (rd_rst && ridx == 6'h32 |-> prdata[7:0] == 8'h00)
        else $error("timer control not cleared");
    chk_status_clear: assert property (rd_rst && ridx == 6'h03 |-> prdata[7:5] == 3'b000)
        else $error("status upper bits not cleared");
endmodule

bind rsi_top rsi_assertions u_chk (
    .clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .supply_below(supply_below),
    .external_reset_pin_n(external_reset_pin_n), .wakeup_event(wakeup_event),
    .watchdog_timeout(watchdog_timeout), .core_reset(core_reset),
    .restart_address(restart_address), .brownout_level_select(brownout_level_select)
);

// >>> dv/rsi_top_tb.sv
`timescale 1ns/1ps
module rsi_top_tb;
    logic        clock, rst_n, psel, penable, pwrite, pready, pslverr, irq;
    logic        external_reset_pin_n, wakeup_event, watchdog_timeout;
    logic        core_sleeping, comparator_result, core_reset;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rdata;
    logic [3:0]  pstrb;
    logic [2:0]  supply_below;
    logic [11:0] restart_address;
    logic [1:0]  brownout_level_select;
    logic        rerr;
    int          miscompares, cmp_count;
    // Index, mask, expected value after any reset
    localparam logic [23:0] INIT_TAB [22] = '{24'h06ffff, 24'h07ff1f, 24'h08ffff,
        24'h0cffff, 24'h14ffff, 24'h15ffff, 24'h16ffff, 24'h19ffff, 24'h1affff,
        24'h1effff, 24'h1fffff, 24'h23ffff, 24'h25ff01, 24'h26ff00, 24'h27ff00,
        24'h2bff00, 24'h2cff01, 24'h32ff00, 24'h02ffff, 24'h03e000, 24'h048080,
        24'h12c1c1};
    // Kind, sleeping, level, expected timeout and powerdown bits
    localparam logic [15:0] KIND_TAB [8] = '{16'h3100, 16'h3001, 16'h4102, 16'h4002,
        16'h1102, 16'h2003, 16'h2013, 16'h2023};

    rsi_top dut (
        .clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .supply_below(supply_below),
        .external_reset_pin_n(external_reset_pin_n), .wakeup_event(wakeup_event),
        .watchdog_timeout(watchdog_timeout), .core_sleeping(core_sleeping),
        .comparator_result(comparator_result), .core_reset(core_reset),
        .restart_address(restart_address), .brownout_level_select(brownout_level_select),
        .irq(irq)
    );

    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    task automatic tally_and_finish;
        if (miscompares == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [5:0] idx, input logic [7:0] d);
        @(posedge clock);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= {idx, 2'b00};
        pwdata <= {24'h000000, d};
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1)
            @(posedge clock);
        rdata = prdata;
        rerr  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [5:0] idx, input logic [7:0] m, input logic [7:0] e);
        apb(1'b0, idx, 8'h00);
        check(rdata & {24'h000000, m}, {24'h000000, e & m});
    endtask

    task automatic check_init;
        foreach (INIT_TAB[i]) rd(INIT_TAB[i][21:16], INIT_TAB[i][15:8], INIT_TAB[i][7:0]);
    endtask

    task automatic wait_free;
        int n;
        n = 0;
        while (core_reset !== 1'b0 && n < 300) begin
            n++;
            @(posedge clock);
        end
        check(32'(n < 300), 32'h1);
        check(32'(restart_address), 32'hfff);
    endtask

    task automatic set_src(input logic [2:0] k, input logic [1:0] lv, input logic v);
        wakeup_event         <= v & (k == rsi_pkg::KIND_WAKEUP);
        supply_below         <= {3{v & (k == rsi_pkg::KIND_BROWNOUT)}} & (3'b001 << lv);
        watchdog_timeout     <= v & (k == rsi_pkg::KIND_WATCHDOG);
        external_reset_pin_n <= ~(v & (k == rsi_pkg::KIND_EXTERNAL));
    endtask

    task automatic run_kind(input logic [15:0] e);
        logic [2:0] k;
        logic [1:0] lv;
        logic [7:0] m;
        k  = e[14:12];
        lv = e[5:4];
        m  = 8'h01 << k;
        apb(1'b1, 6'h3a, {6'h00, lv});
        apb(1'b1, 6'h05, 8'h5a);
        apb(1'b1, 6'h0d, 8'ha5);
        apb(1'b1, 6'h25, 8'h34);
        apb(1'b1, 6'h02, 8'h12);
        check(32'(brownout_level_select), 32'(lv));
        core_sleeping <= e[8];
        supply_below  <= ~(3'b001 << lv);
        repeat (3) @(posedge clock);
        check(32'(core_reset), 32'h0);
        set_src(k, lv, 1'b1);
        repeat (2) @(posedge clock);
        check(32'(core_reset), 32'h1);
        apb(1'b1, 6'h06, 8'h00);
        check_init();
        check(32'(core_reset), 32'h1);
        set_src(k, lv, 1'b0);
        core_sleeping <= 1'b0;
        wait_free();
        rd(6'h3b, 8'h07, {5'h00, k});
        rd(6'h03, 8'h18, {3'b000, e[1:0], 3'b000});
        rd(6'h05, 8'hff, (k == rsi_pkg::KIND_BROWNOUT) ? 8'h00 : 8'h5a);
        rd(6'h0d, 8'hff, (k == rsi_pkg::KIND_BROWNOUT) ? 8'h00 : 8'ha5);
        rd(6'h25, 8'hff, 8'h01);
        rd(6'h06, 8'hff, 8'hff);
        rd(6'h38, m, m);
        check(32'(irq), 32'h0);
        apb(1'b1, 6'h39, m);
        repeat (2) @(posedge clock);
        check(32'(irq), 32'h1);
        apb(1'b1, 6'h38, 8'h1f);
        repeat (2) @(posedge clock);
        check(32'(irq), 32'h0);
        rd(6'h38, 8'h1f, 8'h00);
        apb(1'b1, 6'h39, 8'h00);
    endtask

    initial begin
        repeat (20000) @(posedge clock);
        miscompares++;
        tally_and_finish();
    end

    initial begin
        miscompares = 0;
        cmp_count = 0;
        {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
        {wakeup_event, watchdog_timeout, core_sleeping, comparator_result} = '0;
        supply_below = 3'b000;
        external_reset_pin_n = 1'b1;
        pstrb = 4'hf;
        repeat (10) @(posedge clock);
        rst_n <= 1'b1;
        check_init();
        wait_free();
        rd(6'h38, 8'hff, 8'h01);
        apb(1'b1, 6'h12, 8'h00);
        comparator_result <= 1'b1;
        rd(6'h12, 8'hc1, 8'h01);
        apb(1'b0, 6'h00, 8'h00);
        check(32'(rerr), 32'h1);
        check(rdata, 32'h0);
        apb(1'b1, 6'h3c, 8'h5a);
        check(32'(rerr), 32'h1);
        foreach (KIND_TAB[i]) run_kind(KIND_TAB[i]);
        tally_and_finish();
    end
endmodule

// >>> hw/rsi_reset_arbiter.sv
`timescale 1ns/1ps
module rsi_reset_arbiter (
    input  wire logic              clock,                 // Core clock
    input  wire logic              rst_n,                 // Power-on reset
    input  wire logic [1:0]        brownout_level_select, // Threshold choice
    input  wire logic [2:0]        supply_below,          // Supply under 2.2/2.4/4.1 V
    input  wire logic              external_reset_pin_n,  // Reset pin level
    input  wire logic              wakeup_event,          // Wakeup request
    input  wire logic              watchdog_timeout,      // Watchdog expiry
    input  wire logic              core_sleeping,         // Core in power-down
    output rsi_pkg::rsi_kind_t     reset_kind,            // Latest reset type
    output logic                   reset_in_powerdown,    // Sleep at reset entry
    output logic                   core_reset,            // Internal reset
    output logic [4:0]             cause_event            // One-hot kind pulse
);
    typedef enum logic {
        ST_RUN  = 1'b0,
        ST_HOLD = 1'b1
    } rsi_arb_state_t;

    rsi_arb_state_t            state;
    logic [rsi_pkg::HOLD_W-1:0] hold_count;
    logic                      brownout_active;
    logic                      level_req;
    logic                      any_req;
    rsi_pkg::rsi_kind_t        pick;
    logic                      take;

    function automatic logic [2:0] rank(rsi_pkg::rsi_kind_t k);
        case (k)
            rsi_pkg::KIND_POWER_ON: return 3'h4;
            rsi_pkg::KIND_BROWNOUT: return 3'h3;
            rsi_pkg::KIND_EXTERNAL: return 3'h2;
            rsi_pkg::KIND_WATCHDOG: return 3'h1;
            default:                return 3'h0;
        endcase
    endfunction

    always_comb begin
        case (brownout_level_select)
            rsi_pkg::BOR_2V2: brownout_active = supply_below[rsi_pkg::SUP_2V2];
            rsi_pkg::BOR_2V4: brownout_active = supply_below[rsi_pkg::SUP_2V4];
            default:          brownout_active = supply_below[rsi_pkg::SUP_4V1];
        endcase
    end

    assign level_req = brownout_active | ~external_reset_pin_n;
    assign any_req   = level_req | wakeup_event | watchdog_timeout;

    always_comb begin
        if (brownout_active)
            pick = rsi_pkg::KIND_BROWNOUT;
        else if (!external_reset_pin_n)
            pick = rsi_pkg::KIND_EXTERNAL;
        else if (watchdog_timeout)
            pick = rsi_pkg::KIND_WATCHDOG;
        else
            pick = rsi_pkg::KIND_WAKEUP;
    end

    assign take = any_req && (state == ST_RUN || rank(pick) > rank(reset_kind));

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state <= ST_HOLD;
        end else begin
            case (state)
                ST_RUN: begin
                    if (any_req)
                        state <= ST_HOLD;
                end
                ST_HOLD: begin
                    if (!any_req && hold_count == rsi_pkg::HOLD_LAST)
                        state <= ST_RUN;
                end
                default: state <= ST_RUN;
            endcase
        end
    end

    // Hold time restarts while any source is still present
    always_ff @(posedge clock) begin
        if (!rst_n || any_req)
            hold_count <= '0;
        else if (state == ST_HOLD && hold_count != rsi_pkg::HOLD_LAST)
            hold_count <= hold_count + 1'b1;
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            reset_kind         <= rsi_pkg::KIND_POWER_ON;
            reset_in_powerdown <= 1'b0;
        end else if (take) begin
            reset_kind <= pick;
            if (state == ST_RUN)
                reset_in_powerdown <= core_sleeping;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n)
            cause_event <= '0;
        else
            cause_event <= take ? 5'(1 << pick) : 5'h00;
    end

    assign core_reset = (state == ST_HOLD);
endmodule

// >>> hw/rsi_top.sv
`timescale 1ns/1ps
module rsi_top (
    input  wire logic        clock,                 // Core clock, 50 MHz
    input  wire logic        rst_n,                 // Power-on reset, active low
    input  wire logic        psel,                  // APB select
    input  wire logic        penable,               // APB enable
    input  wire logic        pwrite,                // APB write
    input  wire logic [7:0]  paddr,                 // APB byte address
    input  wire logic [31:0] pwdata,                // APB write data
    input  wire logic [3:0]  pstrb,                 // APB byte strobes
    output logic      [31:0] prdata,                // APB read data
    output logic             pready,                // APB ready
    output logic             pslverr,               // APB error
    input  wire logic [2:0]  supply_below,          // Supply monitor outputs
    input  wire logic        external_reset_pin_n,  // Reset pin
    input  wire logic        wakeup_event,          // Wakeup request
    input  wire logic        watchdog_timeout,      // Watchdog expiry
    input  wire logic        core_sleeping,         // Core in power-down
    input  wire logic        comparator_result,     // Comparator output
    output logic             core_reset,            // Internal reset
    output logic      [11:0] restart_address,       // Fetch address after reset
    output logic      [1:0]  brownout_level_select, // Selected threshold
    output logic             irq                    // Reset-cause interrupt
);
    logic [7:0]              core_reg [0:rsi_pkg::NUM_CORE-1];
    logic [7:0]              extended_fuse_word;
    logic [4:0]              reset_cause;
    logic [4:0]              cause_mask;
    logic [4:0]              cause_event;
    rsi_pkg::rsi_kind_t      reset_kind;
    logic                    reset_in_powerdown;
    logic [5:0]              idx;
    logic                    core_hit;
    logic                    ctl_hit;
    logic                    mapped;
    logic                    setup;
    logic                    access;
    logic                    wr_fire;
    logic [7:0]              next_rdata;
    logic [7:0]              cmp_view;

    rsi_reset_arbiter u_arbiter (
        .clock                 (clock),
        .rst_n                 (rst_n),
        .brownout_level_select (brownout_level_select),
        .supply_below          (supply_below),
        .external_reset_pin_n  (external_reset_pin_n),
        .wakeup_event          (wakeup_event),
        .watchdog_timeout      (watchdog_timeout),
        .core_sleeping         (core_sleeping),
        .reset_kind            (reset_kind),
        .reset_in_powerdown    (reset_in_powerdown),
        .core_reset            (core_reset),
        .cause_event           (cause_event)
    );

    // Per-register load for the current reset type
    function automatic logic [7:0] reset_value(logic [5:0] ridx, logic [7:0] old,
                                              rsi_pkg::rsi_kind_t kind, logic pd);
        logic [7:0] m;
        logic [7:0] base;
        logic [7:0] r;
        logic [1:0] topd;
        m    = rsi_pkg::fixed_mask(ridx);
        base = (kind == rsi_pkg::KIND_POWER_ON || kind == rsi_pkg::KIND_BROWNOUT) ?
               rsi_pkg::ALL_ZERO : old;
        r    = (base & ~m) | (rsi_pkg::fixed_value(ridx) & m);
        if (ridx == rsi_pkg::IDX_STATUS_FLAGS) begin
            topd = {old[rsi_pkg::STATUS_TO_BIT], old[rsi_pkg::STATUS_PD_BIT]};
            case (kind)
                rsi_pkg::KIND_POWER_ON: topd = 2'b11;
                rsi_pkg::KIND_BROWNOUT: topd = 2'b11;
                rsi_pkg::KIND_WATCHDOG: topd = pd ? 2'b00 : 2'b01;
                rsi_pkg::KIND_EXTERNAL: topd = pd ? 2'b10 : topd;
                default:                topd = topd;
            endcase
            r[rsi_pkg::STATUS_TO_BIT] = topd[1];
            r[rsi_pkg::STATUS_PD_BIT] = topd[0];
        end
        return r;
    endfunction

    assign idx      = paddr[7:2];
    assign core_hit = (idx >= rsi_pkg::IDX_REAL_TIME_COUNT) && (idx <= rsi_pkg::IDX_CORE_LAST);
    assign ctl_hit  = (idx >= rsi_pkg::IDX_RESET_CAUSE) && (idx <= rsi_pkg::IDX_RESET_STATE);
    assign mapped   = core_hit | ctl_hit;
    assign setup    = psel & ~penable;
    assign access   = psel & penable;
    assign wr_fire  = access & pwrite & mapped & pstrb[0];
    assign pready   = 1'b1;
    assign pslverr  = access & ~mapped;

    // Core register file; index 0 is unused
    generate
        for (genvar i = 0; i < rsi_pkg::NUM_CORE; i++) begin : g_core
            localparam logic [5:0] RIDX = 6'(i);
            localparam logic [7:0] COLD = reset_value(RIDX, rsi_pkg::ALL_ZERO,
                                                      rsi_pkg::KIND_POWER_ON, 1'b0);
            always_ff @(posedge clock) begin
                if (!rst_n)
                    core_reg[i] <= COLD;
                else if (core_reset)
                    core_reg[i] <= reset_value(RIDX, core_reg[i], reset_kind,
                                               reset_in_powerdown);
                else if (wr_fire && core_hit && idx == RIDX)
                    core_reg[i] <= pwdata[7:0];
            end
        end
    endgenerate

    // Extended fuse word steers the brown-out threshold
    always_ff @(posedge clock) begin
        if (!rst_n)
            extended_fuse_word <= rsi_pkg::FUSE_RESET;
        else if (wr_fire && idx == rsi_pkg::IDX_EXTENDED_FUSE_WORD)
            extended_fuse_word <= pwdata[7:0] & rsi_pkg::FUSE_MASK;
    end

    assign brownout_level_select = extended_fuse_word[1:0];

    // Sticky reset causes, write one to clear; new events win
    always_ff @(posedge clock) begin
        if (!rst_n)
            reset_cause <= rsi_pkg::CAUSE_POR_INIT;
        else if (wr_fire && idx == rsi_pkg::IDX_RESET_CAUSE)
            reset_cause <= (reset_cause & ~pwdata[4:0]) | cause_event;
        else
            reset_cause <= reset_cause | cause_event;
    end

    always_ff @(posedge clock) begin
        if (!rst_n)
            cause_mask <= '0;
        else if (wr_fire && idx == rsi_pkg::IDX_CAUSE_MASK)
            cause_mask <= pwdata[4:0];
    end

    always_ff @(posedge clock) begin
        if (!rst_n)
            irq <= 1'b0;
        else
            irq <= |(reset_cause & cause_mask);
    end

    // Live result replaces the stored bit only while the comparator is disabled
    always_comb begin
        cmp_view = core_reg[rsi_pkg::IDX_COMPARATOR_CONTROL];
        if (!cmp_view[rsi_pkg::CMP_EN_BIT])
            cmp_view[rsi_pkg::CMP_RES_BIT] = comparator_result;
    end

    always_comb begin
        next_rdata = rsi_pkg::ALL_ZERO;
        if (core_hit) begin
            if (idx == rsi_pkg::IDX_COMPARATOR_CONTROL)
                next_rdata = cmp_view;
            else
                next_rdata = core_reg[idx];
        end else if (idx == rsi_pkg::IDX_RESET_CAUSE) begin
            next_rdata = {3'h0, reset_cause};
        end else if (idx == rsi_pkg::IDX_CAUSE_MASK) begin
            next_rdata = {3'h0, cause_mask};
        end else if (idx == rsi_pkg::IDX_EXTENDED_FUSE_WORD) begin
            next_rdata = extended_fuse_word;
        end else if (idx == rsi_pkg::IDX_RESET_STATE) begin
            next_rdata[rsi_pkg::RST_KIND_LSB +: 3] = reset_kind;
            next_rdata[rsi_pkg::RST_PD_BIT]        = reset_in_powerdown;
            next_rdata[rsi_pkg::RST_LIVE_BIT]      = core_reset;
        end
    end

    // Read data captured in the setup cycle
    always_ff @(posedge clock) begin
        if (!rst_n)
            prdata <= '0;
        else if (setup && !pwrite)
            prdata <= {24'h000000, next_rdata};
    end

    always_ff @(posedge clock) begin
        if (!rst_n)
            restart_address <= rsi_pkg::RESTART_ADDR;
        else if (core_reset)
            restart_address <= rsi_pkg::RESTART_ADDR;
        else if (wr_fire && idx == rsi_pkg::IDX_PROGRAM_COUNTER_LOW)
            restart_address <= {rsi_pkg::RESTART_ADDR[11:8], pwdata[7:0]};
    end
endmodule

// >>> inc/rsi_pkg.sv
package rsi_pkg;

    // Clock and reset hold timing
    localparam int unsigned CLK_HZ   = 50_000_000;
    localparam int unsigned HOLD_NS  = 1000;
    localparam int unsigned HOLD_CYC = (HOLD_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int unsigned HOLD_W   = 8;
    localparam logic [HOLD_W-1:0] HOLD_LAST = HOLD_W'(HOLD_CYC - 1);

    localparam logic [11:0] RESTART_ADDR = 12'hfff;

    // Register indices; byte address is four times the index
    localparam int unsigned IDX_W = 6;
    localparam logic [5:0] IDX_REAL_TIME_COUNT     = 6'h01;
    localparam logic [5:0] IDX_PROGRAM_COUNTER_LOW = 6'h02;
    localparam logic [5:0] IDX_STATUS_FLAGS        = 6'h03;
    localparam logic [5:0] IDX_FILE_SELECT_POINTER = 6'h04;
    localparam logic [5:0] IDX_WORKING             = 6'h05;
    localparam logic [5:0] IDX_OPTION              = 6'h06;
    localparam logic [5:0] IDX_MODE                = 6'h07;
    localparam logic [5:0] IDX_PORT_DIR            = 6'h08;
    localparam logic [5:0] IDX_PORT_DATA           = 6'h0d;
    localparam logic [5:0] IDX_COMPARATOR_CONTROL  = 6'h12;
    localparam logic [5:0] IDX_WAKEUP_PENDING      = 6'h13;
    localparam logic [5:0] IDX_WAKEUP_EDGE_SELECT  = 6'h14;
    localparam logic [5:0] IDX_WAKEUP_ENABLE       = 6'h15;
    localparam logic [5:0] IDX_SCHMITT_SELECT      = 6'h16;
    localparam logic [5:0] IDX_INPUT_LEVEL_SELECT  = 6'h1a;
    localparam logic [5:0] IDX_PULLUP_ENABLE       = 6'h1f;
    localparam logic [5:0] IDX_WATCHDOG_COUNT      = 6'h24;
    localparam logic [5:0] IDX_TIMER1              = 6'h25;
    localparam logic [5:0] IDX_TIMER2              = 6'h2c;
    localparam logic [5:0] IDX_CORE_LAST           = 6'h32;
    localparam logic [5:0] IDX_RESET_CAUSE         = 6'h38;
    localparam logic [5:0] IDX_CAUSE_MASK          = 6'h39;
    localparam logic [5:0] IDX_EXTENDED_FUSE_WORD  = 6'h3a;
    localparam logic [5:0] IDX_RESET_STATE         = 6'h3b;
    localparam int unsigned NUM_CORE = 51;
    localparam logic [5:0] PORT_CNT    = 6'h05;
    localparam logic [5:0] SCHMITT_CNT = 6'h04;

    // Timer byte layout within each timer block
    localparam logic [5:0] TIMER_BYTES = 6'h07;
    localparam logic [5:0] TMR_CNT_LO  = 6'h00;
    localparam logic [5:0] TMR_CTL     = 6'h06;

    // Init values
    localparam logic [7:0] ALL_ONES     = 8'hff;
    localparam logic [7:0] ALL_ZERO     = 8'h00;
    localparam logic [7:0] MODE_INIT    = 8'h1f;
    localparam logic [7:0] PC_INIT      = 8'hff;
    localparam logic [7:0] TMR_CNT_INIT = 8'h01;
    localparam logic [7:0] STATUS_MASK  = 8'he0;
    localparam logic [7:0] FSR_MASK     = 8'h80;
    localparam logic [7:0] FSR_INIT     = 8'h80;
    localparam logic [7:0] CMP_MASK     = 8'hc1;
    localparam logic [7:0] CMP_INIT     = 8'hc1;
    localparam int unsigned STATUS_TO_BIT = 4;
    localparam int unsigned STATUS_PD_BIT = 3;
    localparam int unsigned CMP_EN_BIT    = 7;
    localparam int unsigned CMP_RES_BIT   = 0;

    // Extended fuse word and reset state fields
    localparam logic [7:0] FUSE_RESET = 8'h00;
    localparam logic [7:0] FUSE_MASK  = 8'h03;
    localparam int unsigned RST_KIND_LSB = 0;
    localparam int unsigned RST_PD_BIT   = 3;
    localparam int unsigned RST_LIVE_BIT = 4;

    // Brown-out level select encodings and supply monitor bits
    localparam logic [1:0] BOR_2V2 = 2'b00;
    localparam logic [1:0] BOR_2V4 = 2'b01;
    localparam int unsigned SUP_2V2 = 0;
    localparam int unsigned SUP_2V4 = 1;
    localparam int unsigned SUP_4V1 = 2;

    typedef enum logic [2:0] {
        KIND_POWER_ON = 3'b000,
        KIND_WAKEUP   = 3'b001,
        KIND_BROWNOUT = 3'b010,
        KIND_WATCHDOG = 3'b011,
        KIND_EXTERNAL = 3'b100
    } rsi_kind_t;

    localparam int unsigned CAUSE_W = 5;
    localparam logic [4:0] CAUSE_POR_INIT = 5'h01;

    function automatic logic in_range(logic [5:0] idx, logic [5:0] base, logic [5:0] cnt);
        return (idx >= base) && (idx < base + cnt);
    endfunction

    // Bits that every reset forces; others, apart from the status TO and PD bits, are kept, or cleared by power-on and brown-out
    function automatic logic [7:0] fixed_mask(logic [5:0] idx);
        logic [7:0] m;
        m = ALL_ONES;
        if (idx == IDX_STATUS_FLAGS)
            m = STATUS_MASK;
        else if (idx == IDX_FILE_SELECT_POINTER)
            m = FSR_MASK;
        else if (idx == IDX_COMPARATOR_CONTROL)
            m = CMP_MASK;
        else if (idx == IDX_REAL_TIME_COUNT || idx == IDX_WORKING ||
                 idx == IDX_WAKEUP_PENDING || idx == IDX_WATCHDOG_COUNT ||
                 in_range(idx, IDX_PORT_DATA, PORT_CNT))
            m = ALL_ZERO;
        return m;
    endfunction

    function automatic logic [7:0] fixed_value(logic [5:0] idx);
        logic [7:0] v;
        v = ALL_ONES;
        if (idx == IDX_MODE)
            v = MODE_INIT;
        else if (idx == IDX_STATUS_FLAGS)
            v = ALL_ZERO;
        else if (idx == IDX_FILE_SELECT_POINTER)
            v = FSR_INIT;
        else if (idx == IDX_COMPARATOR_CONTROL)
            v = CMP_INIT;
        else if (in_range(idx, IDX_TIMER1, TIMER_BYTES))
            v = (idx - IDX_TIMER1 == TMR_CNT_LO) ? TMR_CNT_INIT : ALL_ZERO;
        else if (in_range(idx, IDX_TIMER2, TIMER_BYTES))
            v = (idx - IDX_TIMER2 == TMR_CNT_LO) ? TMR_CNT_INIT : ALL_ZERO;
        return v;
    endfunction

endpackage
